// ---- bench/host_model.sv ----
// Host controller model: an Avalon master that writes and reads the register slice.
`timescale 1ns/1ps
module host_model (
  input wire logic ref_clk, // clock
  input wire logic [31:0] readdata, // read data
  input wire logic waitrequest, // wait
  output logic [11:0] address, // byte address
  output logic read, // read request
  output logic write, // write request
  output logic [31:0] writedata, // write data
  output logic [3:0] byteenable // byte enables
);
  initial begin
    address = 12'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
  end
  // Data is inverted on release so a slave that samples late sees garbage, not the old value.
  task automatic access(input logic [11:0] a, input logic wr, input logic [7:0] d,
      input logic [3:0] be, output logic [31:0] rd);
    @(posedge ref_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h00_0000, d};
    byteenable <= be;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~writedata;
  endtask
endmodule // host_model

// ---- bench/irq_regs_checker.sv ----
// Concurrent checks on the ports of the receiver configuration register slice.
`timescale 1ns/1ps
module irq_regs_checker #(
  parameter int unsigned N_EV = rx_cfg_pkg::N_EVENTS // event count
) (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic ce, // enable
  input wire logic [rx_cfg_pkg::ADDR_W-1:0] address, // address
  input wire logic read, // read
  input wire logic write, // write
  input wire logic [rx_cfg_pkg::DATA_W-1:0] writedata, // write data
  input wire logic [rx_cfg_pkg::BE_W-1:0] byteenable, // byte enables
  input wire logic [rx_cfg_pkg::DATA_W-1:0] readdata, // read data
  input wire logic waitrequest, // wait
  input wire logic [N_EV-1:0] event_pulse, // events
  input wire logic signed [rx_cfg_pkg::DEV_W-1:0] rate_dev, // deviation
  input wire logic rate_accept_q, // accept
  input wire logic rate_limit_active_q, // limit on
  input wire logic [rx_cfg_pkg::REG_W-1:0] rate_tol_neg_thr_q, // low threshold
  input wire logic [rx_cfg_pkg::REG_W-1:0] rate_tol_pos_thr_q, // high threshold
  input wire logic [5:0] poll_active_count_q, // active count
  input wire logic [8:0] poll_idle_count_q, // idle count
  input wire logic irq_q // interrupt
);
  // Shadow of the mask, so the interrupt checks know which events may raise it.
  logic [7:0] mask_q;
  wire logic take = ce && waitrequest;
  wire logic mask_wr = take && write && byteenable[0] && address == 12'h250;
  wire logic [5:0] act_exp = writedata[4:0] == 5'h00 ? 6'h20 : {1'b0, writedata[4:0]};
  wire logic [8:0] idle_exp = writedata[7:0] == 8'h00 ? 9'h100 : {1'b0, writedata[7:0]};
  wire logic acc_exp = rate_dev < 0 ? -int'(rate_dev) <= int'(rate_tol_neg_thr_q)
    : int'(rate_dev) <= int'(rate_tol_pos_thr_q);
  always_ff @(posedge ref_clk) begin
    if (rst)
      mask_q <= 8'h00;
    else if (mask_wr)
      mask_q <= writedata[7:0];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_wait_answer: assert property (take && (read || write) |=> !waitrequest)
    else $error("request not answered in one cycle");
  a_wait_pulse: assert property (ce && !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_active_decode: assert property (mask_wr == 1'b0 && take && write && byteenable[0]
    && address == 12'h258 |-> ##2 poll_active_count_q == $past(act_exp, 2))
    else $error("active count wrong");
  a_idle_decode: assert property (take && write && byteenable[0] && address == 12'h25C
    |-> ##2 poll_idle_count_q == $past(idle_exp, 2)) else $error("idle count wrong");
  a_irq_raise: assert property (ce && |(event_pulse & ~mask_q) |-> ##[1:2] irq_q)
    else $error("unmasked event did not raise interrupt");
  a_irq_masked: assert property ((mask_q == 8'hFF) [*3] |-> !irq_q)
    else $error("interrupt high with all events masked");
  a_rate_off: assert property (!rate_limit_active_q |-> rate_accept_q &&
    rate_tol_neg_thr_q == 8'h00 && rate_tol_pos_thr_q == 8'h00)
    else $error("limit applied while disabled");
  a_rate_window: assert property (rate_limit_active_q && !write |=>
    rate_accept_q == $past(acc_exp)) else $error("rate acceptance disagrees with thresholds");
  a_active_upper: assert property (take && read && address == 12'h258 |=>
    readdata[31:5] == '0) else $error("unused active bits not zero");
  c_write: cover property (take && write);
  c_irq: cover property ($rose(irq_q));
  c_reject: cover property (rate_limit_active_q && !rate_accept_q);
endmodule // irq_regs_checker

bind rx_irq_mask_poll_period_regs irq_regs_checker #(.N_EV(N_EV)) u_irq_regs_checker (
  .ref_clk, .rst, .ce, .address, .read, .write, .writedata, .byteenable, .readdata,
  .waitrequest, .event_pulse, .rate_dev, .rate_accept_q, .rate_limit_active_q,
  .rate_tol_neg_thr_q, .rate_tol_pos_thr_q, .poll_active_count_q, .poll_idle_count_q, .irq_q
);

// ---- bench/testbench.sv ----
// Self-checking testbench for the receiver configuration register slice.
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [11:0] address;
  logic read, write, waitrequest, rate_accept_q, rate_limit_active_q, irq_q;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [7:0] event_pulse = 8'h00;
  logic signed [8:0] rate_dev = 9'sh000;
  logic [7:0] neg_thr_q, pos_thr_q;
  logic [5:0] act_q;
  logic [8:0] idle_q;
  logic [7:0] act_v [4] = '{8'h00, 8'h01, 8'h1F, 8'hFF};
  logic [7:0] idle_v [4] = '{8'h00, 8'h01, 8'hFF, 8'h80};
  logic signed [8:0] dev_v [6] = '{9'sh1F0, 9'sh1EF, 9'sh008, 9'sh009, 9'sh100, 9'sh000};
  logic [5:0] acc_v = 6'h25;
  int miscompares = 0;
  int n_tests = 0;
  always #25 ref_clk = ~ref_clk;
  rx_irq_mask_poll_period_regs i_rx_irq_mask_poll_period_regs (.ref_clk, .rst, .ce,
    .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .event_pulse,
    .rate_dev, .rate_accept_q, .rate_limit_active_q, .rate_tol_neg_thr_q(neg_thr_q),
    .rate_tol_pos_thr_q(pos_thr_q), .poll_active_count_q(act_q), .poll_idle_count_q(idle_q),
    .irq_q);
  host_model u_host (.ref_clk, .readdata, .waitrequest, .address, .read, .write, .writedata,
    .byteenable);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_host.access(a, 1'b1, d, 4'h1, rd);
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] exp);
    u_host.access(a, 1'b0, 8'h00, 4'h1, rd);
    chk(what, rd, {24'h00_0000, exp});
  endtask
  // The interrupt is registered behind the sticky flag, so allow two edges to settle.
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge ref_clk);
    chk("irq", {31'h0000_0000, irq_q}, {31'h0000_0000, exp});
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    event_pulse <= 8'h01 << i;
    @(posedge ref_clk);
    event_pulse <= 8'h00;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rchk("neg_thr", 12'h24C, 8'h23);
    rchk("mask", 12'h250, 8'h00);
    rchk("active", 12'h258, 8'h01);
    rchk("idle", 12'h25C, 8'h01);
    rchk("pos_thr", 12'h248, 8'h1E);
    chk("counts", {act_q, idle_q}, 15'h0201);
    $display("test reset done");
    wr(12'h24C, 8'hA5);
    u_host.access(12'h24C, 1'b1, 8'h3C, 4'h0, rd);
    wr(12'h24D, 8'h3C);
    rchk("neg_thr", 12'h24C, 8'hA5);
    rchk("unmapped", 12'h3FC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(12'h258, act_v[i]);
      rchk("active", 12'h258, act_v[i] & 8'h1F);
      chk("active_count", act_q, act_v[i][4:0] == 5'h00 ? 6'h20 : act_v[i][4:0]);
      wr(12'h25C, idle_v[i]);
      rchk("idle", 12'h25C, idle_v[i]);
      chk("idle_count", idle_q, idle_v[i] == 8'h00 ? 9'h100 : idle_v[i]);
    end
    $display("test poll counts done");
    for (int i = 0; i < 8; i++) begin
      wr(12'h250, ~(8'h01 << i));
      pulse(i);
      irq_chk(1'b1);
      wr(12'h284, 8'h01 << i);
      irq_chk(1'b0);
      wr(12'h250, 8'hFF);
      pulse(i);
      irq_chk(1'b0);
      rchk("status", 12'h284, 8'h01 << i);
      wr(12'h250, 8'h00);
      irq_chk(1'b1);
      wr(12'h284, 8'h01 << i);
      irq_chk(1'b0);
    end
    $display("test interrupts done");
    wr(12'h24C, 8'h10);
    wr(12'h248, 8'h08);
    wr(12'h280, 8'h01);
    rchk("cfg", 12'h280, 8'h01);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      rate_dev <= dev_v[i];
      repeat (3) @(posedge ref_clk);
      chk("accept", {31'h0000_0000, rate_accept_q}, {31'h0000_0000, acc_v[i]});
    end
    chk("limit_on", {rate_limit_active_q, neg_thr_q, pos_thr_q}, 17'h1_1008);
    rate_dev <= 9'sh1EF;
    wr(12'h280, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk("limit_off", {rate_accept_q, neg_thr_q, pos_thr_q}, 17'h1_0000);
    $display("test rate done");
    // An event that arrives while the clock enable is low must leave no trace.
    @(posedge ref_clk);
    ce <= 1'b0;
    event_pulse <= 8'h01;
    @(posedge ref_clk);
    event_pulse <= 8'h00;
    @(posedge ref_clk);
    ce <= 1'b1;
    rchk("frozen", 12'h284, 8'h00);
    $display("test clock enable done");
    pulse(0);
    irq_chk(1'b1);
    wr(12'h250, 8'hF0);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    irq_chk(1'b0);
    rchk("status", 12'h284, 8'h00);
    rchk("neg_thr", 12'h24C, 8'h23);
    rchk("mask", 12'h250, 8'h00);
    rchk("active", 12'h258, 8'h01);
    rchk("idle", 12'h25C, 8'h01);
    chk("counts", {act_q, idle_q}, 15'h0201);
    $display("test second reset done");
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
endmodule // testbench

// ---- hw/rx_cfg_pkg.sv ----
// Constants, offsets and reset values for the receiver configuration register slice.
//
// Contract
// - Negative rate threshold register at 0x093, reset 0x23, applied only when limit enabled.
// - Larger threshold accepts proportionally larger deviation; reset gives about ten percent.
// - Mask register 0x094: bits 0-3 config A, bits 4-7 config B events.
// - Mask bit zero enables event interrupt, one suppresses it; all reset to zero.
// - Active periods field bits 4:0 at 0x096; zero means 32 periods; 7:5 unused.
// - Idle periods 8 bits at 0x097; values 1-255 literal, zero means 256 periods.
// - Active and idle period registers reset to 0x01, one master period each.
// - Positive rate threshold, reset 0x1E, bounds deviation above nominal; same enable.
package rx_cfg_pkg;

  // ------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned BE_W = 4;

  // ------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [9:0] IDX_POS_THR = 10'h092;
  localparam logic [9:0] IDX_NEG_THR = 10'h093;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h094;
  localparam logic [9:0] IDX_ACTIVE = 10'h096;
  localparam logic [9:0] IDX_IDLE = 10'h097;
  localparam logic [9:0] IDX_CR_CFG = 10'h0A0;
  localparam logic [9:0] IDX_EVT_STATUS = 10'h0A1;
  localparam logic [1:0] WORD_LSB = 2'h0;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_POS_THR = 8'h1E;
  localparam logic [7:0] RST_NEG_THR = 8'h23;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [4:0] RST_ACTIVE = 5'h01;
  localparam logic [7:0] RST_IDLE = 8'h01;
  localparam logic RST_LIMIT_EN = 1'b0;

  // ------------------------------------------------------------------
  // Field layouts
  // ------------------------------------------------------------------
  localparam int unsigned ACTIVE_W = 5;
  localparam int unsigned IDLE_W = 8;
  localparam int unsigned LIMIT_EN_BIT = 0;
  localparam int unsigned N_EVENTS = 8;
  // Event bit order inside each configuration nibble.
  localparam int unsigned EV_WAKEUP = 0;
  localparam int unsigned EV_FRAME_SYNC = 1;
  localparam int unsigned EV_ID_FOUND = 2;
  localparam int unsigned EV_MSG_END = 3;
  localparam int unsigned CFG_B_BASE = 4;

  // Decoded period counts: stored zero stands for the full range.
  localparam logic [5:0] ACTIVE_ZERO_COUNT = 6'h20;
  localparam logic [8:0] IDLE_ZERO_COUNT = 9'h100;

  // Rate deviation from clock recovery, signed, same unit as the thresholds.
  localparam int unsigned DEV_W = 9;

  // Reserved bits and unmapped addresses read as zero.
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

// ---- hw/rx_irq_mask_poll_period_regs.sv ----
// Register slice: rate thresholds, event interrupt mask and self-polling period counts.
`timescale 1ns/1ps
module rx_irq_mask_poll_period_regs #(
  parameter int unsigned N_EV = rx_cfg_pkg::N_EVENTS // number of receive events
) (
  input wire logic ref_clk, // system clock, 20 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, all state frozen while low
  input wire logic [rx_cfg_pkg::ADDR_W-1:0] address, // Avalon byte address
  input wire logic read, // Avalon read request
  input wire logic write, // Avalon write request
  input wire logic [rx_cfg_pkg::DATA_W-1:0] writedata, // Avalon write data
  input wire logic [rx_cfg_pkg::BE_W-1:0] byteenable, // Avalon byte enables
  output logic [rx_cfg_pkg::DATA_W-1:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait request
  input wire logic [N_EV-1:0] event_pulse, // receive events, one-cycle pulses
  input wire logic signed [rx_cfg_pkg::DEV_W-1:0] rate_dev, // measured rate deviation
  output logic rate_accept_q, // measured rate within tolerance
  output logic rate_limit_active_q, // rate limiting in force
  output logic [rx_cfg_pkg::REG_W-1:0] rate_tol_neg_thr_q, // applied negative threshold
  output logic [rx_cfg_pkg::REG_W-1:0] rate_tol_pos_thr_q, // applied positive threshold
  output logic [5:0] poll_active_count_q, // active phase length, 1 to 32
  output logic [8:0] poll_idle_count_q, // idle phase length, 1 to 256
  output logic irq_q // level interrupt
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [rx_cfg_pkg::REG_W-1:0] neg_thr_q;
  logic [rx_cfg_pkg::REG_W-1:0] pos_thr_q;
  logic [N_EV-1:0] irq_mask_low_q;
  logic [rx_cfg_pkg::ACTIVE_W-1:0] poll_active_periods_q;
  logic [rx_cfg_pkg::IDLE_W-1:0] poll_idle_periods_q;
  logic rate_limit_enable_q;
  logic [N_EV-1:0] evt_flag;
  logic [N_EV-1:0] evt_clr;
  logic [rx_cfg_pkg::DATA_W-1:0] readdata_q;
  logic waitrequest_q;
  logic [rx_cfg_pkg::DATA_W-1:0] readdata_d;
  logic req;
  logic take;
  logic lane0;
  logic [9:0] reg_idx;
  logic word_ok;
  logic wr_neg;
  logic wr_pos;
  logic wr_mask;
  logic wr_active;
  logic wr_idle;
  logic wr_cfg;
  logic wr_status;
  logic [rx_cfg_pkg::REG_W-1:0] wbyte;
  logic [rx_cfg_pkg::DEV_W-1:0] dev_mag;
  logic dev_below;
  logic accept_d;
  logic [5:0] active_count_d;
  logic [8:0] idle_count_d;

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  // A request is served in the cycle in which it appears; waitrequest then
  // drops for one cycle, and the slave ignores the request in that cycle
  // so that a held request is not served twice.
  assign req = read | write;
  assign take = req & waitrequest_q;
  assign lane0 = byteenable[0];
  assign reg_idx = address[rx_cfg_pkg::ADDR_W-1:2];
  assign word_ok = (address[1:0] == rx_cfg_pkg::WORD_LSB);
  assign wbyte = writedata[rx_cfg_pkg::REG_W-1:0];

  always_comb begin
    wr_neg = 1'b0;
    wr_pos = 1'b0;
    wr_mask = 1'b0;
    wr_active = 1'b0;
    wr_idle = 1'b0;
    wr_cfg = 1'b0;
    wr_status = 1'b0;
    if (take && write && lane0 && word_ok) begin
      unique case (reg_idx)
        rx_cfg_pkg::IDX_NEG_THR: wr_neg = 1'b1;
        rx_cfg_pkg::IDX_POS_THR: wr_pos = 1'b1;
        rx_cfg_pkg::IDX_IRQ_MASK: wr_mask = 1'b1;
        rx_cfg_pkg::IDX_ACTIVE: wr_active = 1'b1;
        rx_cfg_pkg::IDX_IDLE: wr_idle = 1'b1;
        rx_cfg_pkg::IDX_CR_CFG: wr_cfg = 1'b1;
        rx_cfg_pkg::IDX_EVT_STATUS: wr_status = 1'b1;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    readdata_d = rx_cfg_pkg::READ_ZERO;
    if (word_ok) begin
      unique case (reg_idx)
        rx_cfg_pkg::IDX_NEG_THR: readdata_d[rx_cfg_pkg::REG_W-1:0] = neg_thr_q;
        rx_cfg_pkg::IDX_POS_THR: readdata_d[rx_cfg_pkg::REG_W-1:0] = pos_thr_q;
        rx_cfg_pkg::IDX_IRQ_MASK: readdata_d[N_EV-1:0] = irq_mask_low_q;
        rx_cfg_pkg::IDX_ACTIVE: readdata_d[rx_cfg_pkg::ACTIVE_W-1:0] = poll_active_periods_q;
        rx_cfg_pkg::IDX_IDLE: readdata_d[rx_cfg_pkg::IDLE_W-1:0] = poll_idle_periods_q;
        rx_cfg_pkg::IDX_CR_CFG: readdata_d[rx_cfg_pkg::LIMIT_EN_BIT] = rate_limit_enable_q;
        rx_cfg_pkg::IDX_EVT_STATUS: readdata_d[N_EV-1:0] = evt_flag;
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitrequest_q <= 1'b1;
    end else if (ce) begin
      waitrequest_q <= ~take;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readdata_q <= rx_cfg_pkg::READ_ZERO;
    end else if (ce && take && read) begin
      readdata_q <= readdata_d;
    end
  end

  // --------------------------------------------------------------------
  // Rate thresholds
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      neg_thr_q <= rx_cfg_pkg::RST_NEG_THR;
    end else if (ce && wr_neg) begin
      neg_thr_q <= wbyte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_thr_q <= rx_cfg_pkg::RST_POS_THR;
    end else if (ce && wr_pos) begin
      pos_thr_q <= wbyte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rate_limit_enable_q <= rx_cfg_pkg::RST_LIMIT_EN;
    end else if (ce && wr_cfg) begin
      rate_limit_enable_q <= wbyte[rx_cfg_pkg::LIMIT_EN_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Rate acceptance
  // --------------------------------------------------------------------
  // The threshold is a bound on the magnitude of the deviation, so a
  // larger value admits a proportionally wider band on that side.
  assign dev_below = rate_dev[rx_cfg_pkg::DEV_W-1];
  assign dev_mag = dev_below ? (~rate_dev + 1'b1) : rate_dev;

  always_comb begin
    accept_d = 1'b1;
    if (rate_limit_enable_q) begin
      if (dev_below) begin
        accept_d = (dev_mag <= {1'b0, neg_thr_q});
      end else begin
        accept_d = (dev_mag <= {1'b0, pos_thr_q});
      end
    end
  end

  // With limiting off the thresholds are not applied and the applied-threshold outputs show zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rate_accept_q <= 1'b1;
      rate_limit_active_q <= 1'b0;
      rate_tol_neg_thr_q <= '0;
      rate_tol_pos_thr_q <= '0;
    end else if (ce) begin
      rate_accept_q <= accept_d;
      rate_limit_active_q <= rate_limit_enable_q;
      rate_tol_neg_thr_q <= rate_limit_enable_q ? neg_thr_q : '0;
      rate_tol_pos_thr_q <= rate_limit_enable_q ? pos_thr_q : '0;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt mask and event flags
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_mask_low_q <= rx_cfg_pkg::RST_IRQ_MASK[N_EV-1:0];
    end else if (ce && wr_mask) begin
      irq_mask_low_q <= wbyte[N_EV-1:0];
    end
  end

  assign evt_clr = wr_status ? wbyte[N_EV-1:0] : '0;

  generate
    for (genvar i = 0; i < N_EV; i++) begin : g_evt
      sticky_event_bit u_flag (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .set_pulse(event_pulse[i]),
        .clr_pulse(evt_clr[i]),
        .flag_q(evt_flag[i])
      );
    end
  endgenerate

  // A set mask bit suppresses only the interrupt; the flag still records.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(evt_flag & ~irq_mask_low_q);
    end
  end

  // --------------------------------------------------------------------
  // Self-polling period counts
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      poll_active_periods_q <= rx_cfg_pkg::RST_ACTIVE;
    end else if (ce && wr_active) begin
      poll_active_periods_q <= wbyte[rx_cfg_pkg::ACTIVE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      poll_idle_periods_q <= rx_cfg_pkg::RST_IDLE;
    end else if (ce && wr_idle) begin
      poll_idle_periods_q <= wbyte;
    end
  end

  always_comb begin
    if (poll_active_periods_q == '0) begin
      active_count_d = rx_cfg_pkg::ACTIVE_ZERO_COUNT;
    end else begin
      active_count_d = {1'b0, poll_active_periods_q};
    end
    if (poll_idle_periods_q == '0) begin
      idle_count_d = rx_cfg_pkg::IDLE_ZERO_COUNT;
    end else begin
      idle_count_d = {1'b0, poll_idle_periods_q};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      poll_active_count_q <= {1'b0, rx_cfg_pkg::RST_ACTIVE};
      poll_idle_count_q <= {1'b0, rx_cfg_pkg::RST_IDLE};
    end else if (ce) begin
      poll_active_count_q <= active_count_d;
      poll_idle_count_q <= idle_count_d;
    end
  end

endmodule // rx_irq_mask_poll_period_regs

// ---- hw/sticky_event_bit.sv ----
// One sticky event flag, set by hardware and cleared by writing a one.
`timescale 1ns/1ps
module sticky_event_bit (
  input wire logic ref_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes the flag when low
  input wire logic set_pulse, // event from the receive logic
  input wire logic clr_pulse, // write-one-to-clear strobe
  output logic flag_q // pending flag
);

  // --------------------------------------------------------------------
  // Flag
  // --------------------------------------------------------------------
  // An event in the clear cycle must not be lost, so the set wins.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (set_pulse) begin
        flag_q <= 1'b1;
      end else if (clr_pulse) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule // sticky_event_bit
